//--- hdl/rtc_core_regs.svh
// register map, field positions, reset values and timing of the rtc core
`ifndef RTC_CORE_REGS_SVH
`define RTC_CORE_REGS_SVH
`define REG_SEC 5'h00
`define REG_MIN 5'h01
`define REG_HOUR 5'h02
`define REG_WDAY 5'h03
`define REG_MDAY 5'h04
`define REG_MONTH 5'h05
`define REG_YEAR 5'h06
`define REG_A1_SEC 5'h07
`define REG_A1_MIN 5'h08
`define REG_A1_HOUR 5'h09
`define REG_A1_DD 5'h0A
`define REG_A2_MIN 5'h0B
`define REG_A2_HOUR 5'h0C
`define REG_A2_DD 5'h0D
`define REG_CTRL 5'h0E
`define REG_STAT 5'h0F
`define REG_LAST 5'h10
`define BIT_MASK 7
`define BIT_DYDT 6
`define BIT_HR12 6
`define BIT_PM 5
`define BIT_CENTURY 7
`define BIT_OSC_STOP 7
`define BIT_BACKUP_EN 5
`define BIT_RATE_HI 4
`define BIT_RATE_LO 3
`define BIT_IRQ_SEL 2
`define BIT_A2_IE 1
`define BIT_A1_IE 0
`define BIT_OSF 7
`define BIT_A2F 1
`define BIT_A1F 0
`define CTRL_RESET 8'h18
`define STAT_RESET 8'h80
`define DAY_ONE 8'h01
`define OSC_HZ 32768
`define WAVE_RISE_MS 500
`endif

//--- hdl/rtc_pkg.sv
// shared types of the rtc core and its serial link
package rtc_pkg;
    typedef logic [6:0][7:0] time_regs_t;
    typedef struct packed {
        logic start;
        logic stop;
        logic wr;
        logic first;
        logic rd;
        logic [7:0] data;
    } link_evt_t;
    typedef enum logic [2:0] {
        L_IDLE,
        L_ADDR,
        L_ADDR_ACK,
        L_WR,
        L_WR_ACK,
        L_RD,
        L_RD_ACK
    } link_state_t;
endpackage

//--- hdl/rtc_byte_link.sv
// serial two-wire byte link: start/stop detect, address, write and read bytes
`timescale 1ns/1ns
module rtc_byte_link
    import rtc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h68
)
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_out,
    // byte side
    input wire logic [7:0] rd_data_in,
    output link_evt_t evt_out
);
    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        link_state_t st;
        logic [3:0] bits;
        logic [7:0] shift;
        logic rnw;
        logic first;
        logic sda_oe;
        link_evt_t evt;
    } link_reg_t;
    link_reg_t q_ff;
    link_reg_t nxt_q;
    logic rise, fall, sda_hi, start, stop;
    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.scl_s = {q_ff.scl_s[1:0], scl_in};
        nxt_q.sda_s = {q_ff.sda_s[1:0], sda_in};
        nxt_q.evt = '0;
        // only the second and third stages are read, never the first
        rise = q_ff.scl_s[1] & ~q_ff.scl_s[2];
        fall = ~q_ff.scl_s[1] & q_ff.scl_s[2];
        sda_hi = q_ff.sda_s[1];
        start = q_ff.scl_s[1] & q_ff.scl_s[2] & ~sda_hi & q_ff.sda_s[2];
        stop = q_ff.scl_s[1] & q_ff.scl_s[2] & sda_hi & ~q_ff.sda_s[2];
        if (start)
        begin
            nxt_q.st = L_ADDR;
            nxt_q.bits = 4'h0;
            nxt_q.sda_oe = 1'b0;
            nxt_q.first = 1'b1;
            nxt_q.evt.start = 1'b1;
        end
        else if (stop)
        begin
            nxt_q.st = L_IDLE;
            nxt_q.sda_oe = 1'b0;
            nxt_q.evt.stop = 1'b1;
        end
        else
        begin
            case (q_ff.st)
                L_IDLE:
                begin
                    nxt_q.sda_oe = 1'b0;
                end
                L_ADDR, L_WR:
                begin
                    if (rise)
                    begin
                        nxt_q.shift = {q_ff.shift[6:0], sda_hi};
                        nxt_q.bits = q_ff.bits + 4'h1;
                    end
                    if (fall && q_ff.bits == 4'h8)
                    begin
                        nxt_q.bits = 4'h0;
                        if (q_ff.st == L_WR)
                        begin
                            nxt_q.sda_oe = 1'b1;
                            nxt_q.st = L_WR_ACK;
                        end
                        else if (q_ff.shift[7:1] == DEV_ADDR)
                        begin
                            nxt_q.sda_oe = 1'b1;
                            nxt_q.rnw = q_ff.shift[0];
                            nxt_q.st = L_ADDR_ACK;
                        end
                        else
                        begin
                            nxt_q.st = L_IDLE;
                        end
                    end
                end
                L_WR_ACK:
                begin
                    // the byte is handed over on the ack clock pulse
                    if (rise)
                    begin
                        nxt_q.evt.wr = 1'b1;
                        nxt_q.evt.first = q_ff.first;
                        nxt_q.evt.data = q_ff.shift;
                    end
                    if (fall)
                    begin
                        nxt_q.sda_oe = 1'b0;
                        nxt_q.first = 1'b0;
                        nxt_q.st = L_WR;
                    end
                end
                L_RD:
                begin
                    if (fall)
                    begin
                        nxt_q.bits = q_ff.bits + 4'h1;
                        nxt_q.shift = {q_ff.shift[6:0], 1'b0};
                        nxt_q.sda_oe = ~q_ff.shift[6];
                        if (q_ff.bits == 4'h7)
                        begin
                            nxt_q.sda_oe = 1'b0;
                            nxt_q.st = L_RD_ACK;
                        end
                    end
                end
                L_ADDR_ACK, L_RD_ACK:
                begin
                    // a nack from the master ends the read
                    if (rise && q_ff.st == L_RD_ACK && sda_hi)
                    begin
                        nxt_q.st = L_IDLE;
                    end
                    else if (fall && (q_ff.rnw || q_ff.st == L_RD_ACK))
                    begin
                        nxt_q.shift = rd_data_in;
                        nxt_q.sda_oe = ~rd_data_in[7];
                        nxt_q.evt.rd = 1'b1;
                        nxt_q.bits = 4'h0;
                        nxt_q.st = L_RD;
                    end
                    else if (fall)
                    begin
                        nxt_q.sda_oe = 1'b0;
                        nxt_q.first = 1'b1;
                        nxt_q.st = L_WR;
                    end
                end
                default:
                begin
                    nxt_q.st = L_IDLE;
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            q_ff <= '{scl_s: 3'h7, sda_s: 3'h7, st: L_IDLE, default: '0};
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end
    assign sda_oe_out = q_ff.sda_oe;
    assign evt_out = q_ff.evt;
endmodule

//--- hdl/rtc_core.sv
// timekeeping, alarms, register map and shared wave/irq output of the rtc
//
// Behaviour
// - pointer advances per byte, wraps last to zero
// - start, stop or pointer wrap refresh read shadows
// - time and date held in packed bcd
// - hours bit 6 picks 12 or 24 hour
// - hours bit 5 is pm or tens-of-hours
// - century bit flips when year wraps 99
// - weekday counts 1 to 7 at midnight
// - seconds write restarts the sub-second chain
// - written byte lands at its ack pulse
// - 1 Hz wave rises 500 ms after seconds write
// - alarm one at 07h-0Ah, two at 0Bh-0Dh
// - bit 7 masks; unmasked fields must all match
// - bit 6 picks date or weekday compare
// - alarms checked each second, set flags
// - irq needs flag, enable and irq select
// - backup enable keeps output alive on battery
// - irq holds until its flag is cleared
// - first alarm mask patterns as tabulated
// - second alarm mask patterns, minute at 00 seconds
// - writing zero clears a flag, one keeps it
// - irq select low puts square wave out
`include "rtc_core_regs.svh"
`timescale 1ns/1ns
module rtc_core
    import rtc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h68,
    parameter int CHAIN_W = 15
)
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // serial bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_drv_out,
    output logic sda_oe_out,
    // oscillator and supply
    input wire logic osc_32k_in,
    input wire logic on_backup_in,
    // shared wave or interrupt pin, open drain
    output logic wave_or_irq_drv_out,
    output logic wave_or_irq_oe_out
);
    generate
        if (CHAIN_W < 3 || (1 << CHAIN_W) != `OSC_HZ)
        begin : g_bad_chain
            $error("sub-second chain must divide the oscillator to 1 Hz");
        end
    endgenerate

    typedef struct packed {
        logic [2:0] osc_s;
        logic [1:0] bak_s;
        logic [CHAIN_W-1:0] chain;
        logic sec_tick;
        logic eval;
        logic [16:0][7:0] regs;
        time_regs_t shadow;
        logic [4:0] ptr;
        logic wave_oe;
        logic drv_low;
    } core_reg_t;
    core_reg_t q_ff;
    core_reg_t nxt_q;
    link_evt_t evt;
    logic [7:0] rd_data;
    logic [7:0] ctrl;
    logic [7:0] stat;
    logic [4:0] ptr_next;
    logic osc_edge, hit1, hit2, irq, wave, level;

    ////////////////////////////////////////////////////////////////////////////////
    // bcd helpers: bcd_step returns {carry, next}, month_len returns the last day of the month
    function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] top,
                                            input logic [7:0] low);
        if (v == top)
            bcd_step = {1'b1, low};
        else if (v[3:0] == 4'h9)
            bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
        else
            bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] month_len(input logic [4:0] mon, input logic [7:0] yr);
        logic leap;
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (mon)
            5'h02: month_len = leap ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: month_len = 8'h30;
            default: month_len = 8'h31;
        endcase
    endfunction

    // one second of counting, carried as far as it goes
    function automatic time_regs_t tick_time(input time_regs_t t);
        time_regs_t r;
        logic [8:0] s;
        logic c;
        r = t;
        s = bcd_step(t[`REG_SEC], 8'h59, 8'h00);
        r[`REG_SEC] = s[7:0];
        c = s[8];
        if (c)
        begin
            s = bcd_step(t[`REG_MIN], 8'h59, 8'h00);
            r[`REG_MIN] = s[7:0];
            c = s[8];
        end
        if (c)
        begin
            if (t[`REG_HOUR][`BIT_HR12])
            begin
                // 12 hour: 11 -> 12 flips pm, 12 -> 1, midnight after 11 pm
                c = 1'b0;
                if (t[`REG_HOUR][4:0] == 5'h11)
                begin
                    r[`REG_HOUR][4:0] = 5'h12;
                    r[`REG_HOUR][`BIT_PM] = ~t[`REG_HOUR][`BIT_PM];
                    c = t[`REG_HOUR][`BIT_PM];
                end
                else if (t[`REG_HOUR][4:0] == 5'h12)
                    r[`REG_HOUR][4:0] = 5'h01;
                else
                begin
                    s = bcd_step({3'h0, t[`REG_HOUR][4:0]}, 8'h12, 8'h01);
                    r[`REG_HOUR][4:0] = s[4:0];
                end
            end
            else
            begin
                // 24 hour: bit 5 is the second tens bit
                s = bcd_step({2'h0, t[`REG_HOUR][5:0]}, 8'h23, 8'h00);
                r[`REG_HOUR][5:0] = s[5:0];
                c = s[8];
            end
        end
        if (c)
        begin
            s = bcd_step(t[`REG_WDAY], 8'h07, `DAY_ONE);
            r[`REG_WDAY] = s[7:0];
            s = bcd_step(t[`REG_MDAY], month_len(t[`REG_MONTH][4:0], t[`REG_YEAR]), `DAY_ONE);
            r[`REG_MDAY] = s[7:0];
            c = s[8];
        end
        if (c)
        begin
            s = bcd_step({3'h0, t[`REG_MONTH][4:0]}, 8'h12, `DAY_ONE);
            r[`REG_MONTH][4:0] = s[4:0];
            c = s[8];
        end
        if (c)
        begin
            s = bcd_step(t[`REG_YEAR], 8'h99, 8'h00);
            r[`REG_YEAR] = s[7:0];
            if (s[8])
                r[`REG_MONTH][`BIT_CENTURY] = ~t[`REG_MONTH][`BIT_CENTURY];
        end
        tick_time = r;
    endfunction

    // day or date compare of an alarm byte, used by both alarms
    function automatic logic dd_match(input logic [7:0] a, input time_regs_t t);
        if (a[`BIT_DYDT])
            dd_match = a[5:0] == t[`REG_WDAY][5:0];
        else
            dd_match = a[5:0] == t[`REG_MDAY][5:0];
    endfunction

    // bits that hold storage in each location; the rest read zero
    function automatic logic [7:0] live_bits(input logic [4:0] idx);
        case (idx)
            `REG_SEC, `REG_MIN, `REG_HOUR: live_bits = 8'h7F;
            `REG_WDAY: live_bits = 8'h07;
            `REG_MDAY: live_bits = 8'h3F;
            `REG_MONTH: live_bits = 8'h9F;
            `REG_CTRL: live_bits = 8'hBF;
            default: live_bits = 8'hFF;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    rtc_byte_link #(
        .DEV_ADDR(DEV_ADDR)
    ) i_rtc_byte_link (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_oe_out(sda_oe_out),
        .rd_data_in(rd_data),
        .evt_out(evt)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.osc_s = {q_ff.osc_s[1:0], osc_32k_in};
        nxt_q.bak_s = {q_ff.bak_s[0], on_backup_in};
        nxt_q.sec_tick = 1'b0;
        nxt_q.eval = q_ff.sec_tick;
        // open-drain drive value lives in a flop so no pin output is a bare tie
        nxt_q.drv_low = 1'b0;
        ctrl = q_ff.regs[`REG_CTRL];
        osc_edge = q_ff.osc_s[1] & ~q_ff.osc_s[2];
        // time reads come from the shadow copy so a read never tears
        rd_data = (q_ff.ptr <= `REG_YEAR) ? q_ff.shadow[q_ff.ptr[2:0]] : q_ff.regs[q_ff.ptr];
        ptr_next = (q_ff.ptr >= `REG_LAST) ? 5'h00 : q_ff.ptr + 5'h01;

        // sub-second chain; a stopped oscillator holds it and marks the stop
        if (ctrl[`BIT_OSC_STOP])
            nxt_q.regs[`REG_STAT][`BIT_OSF] = 1'b1;
        else if (osc_edge)
        begin
            nxt_q.chain = q_ff.chain + 1'b1;
            nxt_q.sec_tick = &q_ff.chain;
        end
        if (q_ff.sec_tick)
            nxt_q.regs[6:0] = tick_time(q_ff.regs[6:0]);

        // host side of the register map
        if (evt.start || evt.stop)
            nxt_q.shadow = nxt_q.regs[6:0];
        if (evt.wr && evt.first)
        begin
            // the whole byte is judged, so a pointer of 25h cannot alias onto 05h
            nxt_q.ptr = (evt.data > {3'h0, `REG_LAST}) ? 5'h00 : evt.data[4:0];
        end
        else if (evt.wr || evt.rd)
        begin
            if (evt.wr && q_ff.ptr == `REG_STAT)
            begin
                // flags only clear from the host side
                nxt_q.regs[`REG_STAT] = nxt_q.regs[`REG_STAT] & evt.data & `STAT_RESET
                                        | nxt_q.regs[`REG_STAT] & evt.data & 8'h03;
            end
            else if (evt.wr)
            begin
                // a write lands directly on the counter at its ack pulse
                nxt_q.regs[q_ff.ptr] = evt.data & live_bits(q_ff.ptr);
                if (q_ff.ptr == `REG_SEC)
                begin
                    // a tick raised in this same cycle would step the new seconds
                    nxt_q.chain = '0;
                    nxt_q.sec_tick = 1'b0;
                end
            end
            nxt_q.ptr = ptr_next;
            if (ptr_next == 5'h00)
                nxt_q.shadow = nxt_q.regs[6:0];
        end

        // alarm compare one cycle after the tick, on the settled time
        hit1 = (q_ff.regs[`REG_A1_SEC][`BIT_MASK] |
                q_ff.regs[`REG_A1_SEC][6:0] == q_ff.regs[`REG_SEC][6:0]) &
               (q_ff.regs[`REG_A1_MIN][`BIT_MASK] |
                q_ff.regs[`REG_A1_MIN][6:0] == q_ff.regs[`REG_MIN][6:0]) &
               (q_ff.regs[`REG_A1_HOUR][`BIT_MASK] |
                q_ff.regs[`REG_A1_HOUR][6:0] == q_ff.regs[`REG_HOUR][6:0]) &
               (q_ff.regs[`REG_A1_DD][`BIT_MASK] |
                dd_match(q_ff.regs[`REG_A1_DD], q_ff.regs[6:0]));
        hit2 = (q_ff.regs[`REG_SEC] == 8'h00) &
               (q_ff.regs[`REG_A2_MIN][`BIT_MASK] |
                q_ff.regs[`REG_A2_MIN][6:0] == q_ff.regs[`REG_MIN][6:0]) &
               (q_ff.regs[`REG_A2_HOUR][`BIT_MASK] |
                q_ff.regs[`REG_A2_HOUR][6:0] == q_ff.regs[`REG_HOUR][6:0]) &
               (q_ff.regs[`REG_A2_DD][`BIT_MASK] |
                dd_match(q_ff.regs[`REG_A2_DD], q_ff.regs[6:0]));
        // setting comes after the host clear so a same-cycle match wins
        if (q_ff.eval && hit1)
            nxt_q.regs[`REG_STAT][`BIT_A1F] = 1'b1;
        if (q_ff.eval && hit2)
            nxt_q.regs[`REG_STAT][`BIT_A2F] = 1'b1;

        // shared pin: low-active irq or square wave, released when high
        stat = q_ff.regs[`REG_STAT];
        irq = (stat[`BIT_A1F] & ctrl[`BIT_A1_IE]) | (stat[`BIT_A2F] & ctrl[`BIT_A2_IE]);
        case ({ctrl[`BIT_RATE_HI], ctrl[`BIT_RATE_LO]})
            2'b00: wave = q_ff.chain[CHAIN_W-1];
            2'b01: wave = q_ff.chain[2];
            2'b10: wave = q_ff.chain[1];
            default: wave = q_ff.osc_s[1];
        endcase
        level = ctrl[`BIT_IRQ_SEL] ? ~irq : wave;
        // on battery the pin only works when the backup enable is set
        nxt_q.wave_oe = ~level & (~q_ff.bak_s[1] | ctrl[`BIT_BACKUP_EN]);
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            q_ff <= '0;
            q_ff.regs[`REG_WDAY] <= `DAY_ONE;
            q_ff.regs[`REG_MDAY] <= `DAY_ONE;
            q_ff.regs[`REG_MONTH] <= `DAY_ONE;
            q_ff.regs[`REG_CTRL] <= `CTRL_RESET;
            q_ff.regs[`REG_STAT] <= `STAT_RESET;
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    // open-drain pins only ever pull low
    assign sda_drv_out = q_ff.drv_low;
    assign wave_or_irq_drv_out = q_ff.drv_low;
    assign wave_or_irq_oe_out = q_ff.wave_oe;
endmodule

//--- dv/rtc_core_asserts.sv
// pin-level assertion checker of the rtc core
`timescale 1ns/1ns
module rtc_core_asserts (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_drv_out,
    input wire logic sda_oe_out,
    input wire logic osc_32k_in,
    input wire logic on_backup_in,
    input wire logic wave_or_irq_drv_out,
    input wire logic wave_or_irq_oe_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////
    // device bits change only deep in the scl low phase, never faking a start or stop
    sequence scl_low_two;
        !scl_in && !$past(scl_in);
    endsequence
    sequence ack_stands;
        sda_oe_out [*8];
    endsequence
    sequence release_stands;
        !sda_oe_out [*8];
    endsequence
    ////////////////////////////////////////
    sda_drv_zero_a: assert property (sda_drv_out == 1'b0)
        else $error("sda drive value not zero");
    wave_drv_zero_a: assert property (wave_or_irq_drv_out == 1'b0)
        else $error("wave pin drive value not zero");
    quiet_start_a: assert property ($fell(rst_in) |-> release_stands)
        else $error("sda pulled right after reset");
    ack_hold_a: assert property ($rose(sda_oe_out) |-> ack_stands)
        else $error("sda pull shorter than a bit");
    release_hold_a: assert property ($fell(sda_oe_out) |-> release_stands)
        else $error("sda release shorter than a bit");
    sda_move_a: assert property ($changed(sda_oe_out) |-> scl_low_two)
        else $error("sda moved outside scl low");
    scl_high_still_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out))
        else $error("sda moved while scl high");
    scl_rise_still_a: assert property ($rose(scl_in) |=> $stable(sda_oe_out))
        else $error("sda moved at scl rise");
endmodule
bind rtc_core rtc_core_asserts i_rtc_core_asserts (.clk_sys_in, .rst_in, .scl_in, .sda_in,
    .sda_drv_out, .sda_oe_out, .osc_32k_in, .on_backup_in, .wave_or_irq_drv_out,
    .wave_or_irq_oe_out);

//--- dv/rtc_i2c_host.sv
// two-wire bus host model that drives the rtc bus pins
`timescale 1ns/1ns
module rtc_i2c_host (
    // clock
    input wire logic clk_sys_in,
    // bus
    input wire logic dev_oe_in,
    output logic scl_out,
    output logic sda_out
);
    logic sda_host = 1'b1;
    ////////////////////////////////////////
    // data line has a pull-up: released by both parties it reads high
    assign sda_out = sda_host & ~dev_oe_in;
    initial
    begin
        scl_out = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    // also serves as repeated start: scl low on entry is fine
    task automatic start_cond();
        sda_host <= 1'b1;
        tick(4);
        scl_out <= 1'b1;
        tick(8);
        sda_host <= 1'b0;
        tick(8);
        scl_out <= 1'b0;
        tick(4);
    endtask
    task automatic stop_cond();
        sda_host <= 1'b0;
        tick(4);
        scl_out <= 1'b1;
        tick(8);
        sda_host <= 1'b1;
        tick(8);
    endtask
    // eight bits plus ack, 160 ns each; tx of FF releases the line for reads
    task automatic byte_io(input logic [7:0] tx, input logic ack_bit,
        output logic [7:0] rx, output logic ack_seen);
        logic [8:0] bits;
        bits = {tx, ack_bit};
        for (int i = 8; i >= 0; i--)
        begin
            sda_host <= bits[i];
            tick(4);
            scl_out <= 1'b1;
            tick(4);
            if (i > 0)
                rx[i-1] = sda_out;
            else
                ack_seen = sda_out;
            tick(4);
            scl_out <= 1'b0;
            tick(4);
        end
    endtask
endmodule

//--- dv/rtc_core_tb_top.sv
// self-checking bench of the rtc core behind its bus host model
`timescale 1ns/1ns
module rtc_core_tb_top;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic osc_32k_in = 1'b0;
    logic on_backup_in = 1'b0;
    logic scl;
    logic sda;
    logic sda_oe;
    logic wave_oe;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int osc_n = 0;
    int mark = 0;
    ////////////////////////////////////////
    rtc_core #(.DEV_ADDR(7'h68), .CHAIN_W(15)) i_rtc_core (.clk_sys_in, .rst_in, .scl_in(scl),
        .sda_in(sda), .sda_drv_out(), .sda_oe_out(sda_oe), .osc_32k_in, .on_backup_in,
        .wave_or_irq_drv_out(), .wave_or_irq_oe_out(wave_oe));
    rtc_i2c_host i_rtc_i2c_host (.clk_sys_in, .dev_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
    always #5 clk_sys_in = ~clk_sys_in;
    // oscillator at half the clock rate keeps one second near 65536 cycles
    always @(posedge clk_sys_in)
    begin
        osc_32k_in <= ~osc_32k_in;
        if (!osc_32k_in)
            osc_n <= osc_n + 1;
        cycles <= cycles + 1;
        if (cycles == 95000)
        begin
            fails++;
            give_verdict();
        end
    end
    ////////////////////////////////////////
    task automatic give_verdict();
        if (fails == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_regs(input logic [7:0] ptr, input logic [7:0] q[$]);
        logic [7:0] rx;
        logic ack;
        q.push_front(ptr);
        q.push_front(8'hD0);
        i_rtc_i2c_host.start_cond();
        foreach (q[i])
        begin
            i_rtc_i2c_host.byte_io(q[i], 1'b1, rx, ack);
            chk8({7'h00, ack}, 8'h00);
        end
        i_rtc_i2c_host.stop_cond();
    endtask
    task automatic rd_regs(input logic [7:0] ptr, input logic [7:0] exp[$]);
        logic [7:0] rx;
        logic ack;
        wr_regs(ptr, '{});
        i_rtc_i2c_host.start_cond();
        i_rtc_i2c_host.byte_io(8'hD1, 1'b1, rx, ack);
        chk8({7'h00, ack}, 8'h00);
        foreach (exp[i])
        begin
            i_rtc_i2c_host.byte_io(8'hFF, i == exp.size() - 1, rx, ack);
            chk8(rx, exp[i]);
        end
        i_rtc_i2c_host.stop_cond();
    endtask
    task automatic wait_osc(input int n);
        while (osc_n - mark < n)
            @(posedge clk_sys_in);
    endtask
    ////////////////////////////////////////
    task automatic reset_values();
        rd_regs(8'h0E, '{8'h18, 8'h80});
    endtask
    task automatic pointer_wrap();
        wr_regs(8'h10, '{8'hA5, 8'h59});
        rd_regs(8'h10, '{8'hA5, 8'h59});
        rd_regs(8'h25, '{8'h59});
    endtask
    task automatic calendar_alarm();
        mark = osc_n;
        wr_regs(8'h00, '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99, 8'h80, 8'h80, 8'h80,
            8'h80, 8'h00, 8'h00, 8'h41, 8'h00, 8'h00});
        wait_osc(16000);
        chk8({7'h00, wave_oe}, 8'h01);
        wait_osc(17500);
        chk8({7'h00, wave_oe}, 8'h00);
        wr_regs(8'h0E, '{8'h05});
        chk8({7'h00, wave_oe}, 8'h00);
        wait_osc(34000);
        chk8({7'h00, wave_oe}, 8'h01);
        rd_regs(8'h00, '{8'h00, 8'h00, 8'h00, 8'h01,
            8'h01, 8'h81, 8'h00});
        rd_regs(8'h0F, '{8'h03});
        wr_regs(8'h0F, '{8'h03});
        chk8({7'h00, wave_oe}, 8'h01);
        on_backup_in <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        chk8({7'h00, wave_oe}, 8'h00);
        on_backup_in <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        chk8({7'h00, wave_oe}, 8'h01);
        wr_regs(8'h0F, '{8'h00});
        chk8({7'h00, wave_oe}, 8'h00);
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
        reset_values();
        pointer_wrap();
        calendar_alarm();
        give_verdict();
    end
endmodule
